// ===== rtl/masf_consts.svh
`ifndef MASF_CONSTS_SVH
`define MASF_CONSTS_SVH

// ----------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------
`define MASF_IDX_STATUS_FIRST 8'h41
`define MASF_IDX_STATUS_SECOND 8'h42
`define MASF_IDX_PIN_CONFIG 8'h60

// ----------------------------------------
// reset values
// ----------------------------------------
`define MASF_STATUS_RESET 8'h00
`define MASF_CFG_RESET 4'h0

// ----------------------------------------
// field positions
// ----------------------------------------
`define MASF_B_SUMMARY 7
`define MASF_B_OVERTEMP 1
`define MASF_B_SHARED 5
`define MASF_CFG_PIN22_TIMER 2
`define MASF_CFG_SIXTH_LINE 3

// ----------------------------------------
// timing
// ----------------------------------------
`define MASF_CLK_PERIOD_NS 10
`define MASF_CODE_WINDOW_NS 11000
`define MASF_CODE_CYCLES (`MASF_CODE_WINDOW_NS / `MASF_CLK_PERIOD_NS)

`endif

// ===== rtl/masf_pkg.sv
`default_nettype none

package masf_pkg;

	// ----------------------------------------
	// shared pin (fan-four pin) modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		P14_TACH = 2'b00,
		P14_GPIO_OUT = 2'b01,
		P14_GPIO_IN = 2'b10,
		P14_TIMER = 2'b11
	} masf_pin14_t;

	// ----------------------------------------
	// whole register state of the top module
	// ----------------------------------------
	typedef struct packed {
		logic [6:0] first;
		logic [7:0] second;
		logic [3:0] cfg;
		logic spare;
		logic [31:0] rdata;
	} masf_state_t;

	// ----------------------------------------
	// state of the code change watcher
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] cnt;
		logic [5:0] sample;
		logic primed;
		logic pulse;
	} masf_watch_t;

endpackage : masf_pkg

`default_nettype wire

// ===== rtl/masf_limit_cmp.sv
`default_nettype none

module masf_limit_cmp #(
	parameter int W = 8,
	parameter bit SIGNED = 1'b0
) (
	// reading and its window
	input wire logic [W-1:0] reading,
	input wire logic [W-1:0] low_limit,
	input wire logic [W-1:0] high_limit,
	// result
	output logic out_of_limit
);

	if (W < 2) begin : g_chk
		$error("masf_limit_cmp: W too small");
	end

	// high trips strictly above, low trips at or below
	function automatic logic outside(input logic [W-1:0] v, lo, hi);
		logic over;
		logic under;
		over = SIGNED ? ($signed(v) > $signed(hi)) : (v > hi);
		under = SIGNED ? ($signed(v) <= $signed(lo)) : (v <= lo);
		return over | under;
	endfunction : outside

	assign out_of_limit = outside(reading, low_limit, high_limit);

endmodule : masf_limit_cmp

`default_nettype wire

// ===== rtl/masf_vc_detect.sv
`include "masf_consts.svh"
`default_nettype none

module masf_code_watch #(
	parameter int CYCLES = `MASF_CODE_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// six-line processor voltage code
	input wire logic [5:0] processor_voltage_code,
	// one-cycle pulse when the code moved since the last sample
	output logic change_pulse
);

	if (CYCLES < 2 || CYCLES > 65535) begin : g_chk
		$error("masf_code_watch: CYCLES out of range");
	end

	masf_pkg::masf_watch_t w_reg;
	masf_pkg::masf_watch_t w_next;
	logic window_end;

	assign window_end = (w_reg.cnt == 16'(CYCLES - 1));

	// sample window divider; first sample only primes, so reset never flags
	always_comb begin
		w_next = w_reg;
		w_next.cnt = window_end ? 16'h0000 : w_reg.cnt + 16'h0001;
		w_next.pulse = window_end & w_reg.primed
			& (processor_voltage_code != w_reg.sample);
		if (window_end) begin
			w_next.sample = processor_voltage_code;
			w_next.primed = 1'b1;
		end
	end

	// whole watcher state in one register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			w_reg.cnt <= 16'h0000;
			w_reg.sample <= 6'h00;
			w_reg.primed <= 1'b0;
			w_reg.pulse <= 1'b0;
		end else begin
			w_reg <= w_next;
		end
	end

	assign change_pulse = w_reg.pulse;

endmodule : masf_code_watch

`default_nettype wire

// ===== rtl/masf_top.sv
// Register access over APB was decided locally.
`include "masf_consts.svh"
`default_nettype none

module masf_top #(
	parameter int TACH_W = 16,
	parameter int CODE_CYCLES = `MASF_CODE_CYCLES
) (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// voltage readings and limits: 2.5V, core, supply, 5V, 12V
	input wire logic [4:0][7:0] volt_reading,
	input wire logic [4:0][7:0] volt_low_limit,
	input wire logic [4:0][7:0] volt_high_limit,
	// temperature readings and limits: remote one, local, remote two
	input wire logic [2:0][7:0] temp_reading,
	input wire logic [2:0][7:0] temp_low_limit,
	input wire logic [2:0][7:0] temp_high_limit,
	input wire logic [2:0][7:0] overtemp_limit,
	input wire logic [3:0] overtemp_hysteresis,
	// overtemp assertion timer
	input wire logic [7:0] overtemp_assert_time,
	input wire logic [7:0] overtemp_timer_limit,
	// fans
	input wire logic [3:0][TACH_W-1:0] tach_count,
	input wire logic [3:0][TACH_W-1:0] tach_min_count,
	input wire logic [2:0] fan_drive_on,
	// remote diode faults
	input wire logic diode_one_open_short,
	input wire logic diode_two_open_short,
	// processor voltage code
	input wire logic [5:0] processor_voltage_code,
	// spare pin
	input wire logic spare_io_six_i,
	output logic spare_io_six_o,
	output logic spare_io_six_oe,
	// alert request from the code change flag
	output logic voltage_code_change_flag
);

	if (TACH_W < 2 || TACH_W > 16) begin : g_chk
		$error("masf_top: TACH_W must be 2..16");
	end

	// ----------------------------------------
	// measurement comparisons
	// ----------------------------------------
	logic [4:0] volt_out;
	logic [2:0] temp_out;
	logic code_moved;

	// voltages are unsigned codes
	for (genvar i = 0; i < 5; i++) begin : g_volt
		masf_limit_cmp #(.W(8), .SIGNED(1'b0)) u_cmp (
			.reading(volt_reading[i]),
			.low_limit(volt_low_limit[i]),
			.high_limit(volt_high_limit[i]),
			.out_of_limit(volt_out[i])
		);
	end

	// temperatures are two's complement
	for (genvar i = 0; i < 3; i++) begin : g_temp
		masf_limit_cmp #(.W(8), .SIGNED(1'b1)) u_cmp (
			.reading(temp_reading[i]),
			.low_limit(temp_low_limit[i]),
			.high_limit(temp_high_limit[i]),
			.out_of_limit(temp_out[i])
		);
	end

	// code change detector on the 11 us window
	masf_code_watch #(.CYCLES(CODE_CYCLES)) u_code (
		.pclk(pclk),
		.presetn(presetn),
		.processor_voltage_code(processor_voltage_code),
		.change_pulse(code_moved)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// sticky update: a live cause always wins over the read clear
	function automatic logic [7:0] sticky(input logic [7:0] flag, cause, clr);
		return cause | (flag & ~clr);
	endfunction : sticky

	// register decode on word index
	function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
		return (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
	endfunction : hit

	// still inside the hysteresis band; widened so limit minus band cannot wrap
	function automatic logic in_hyst_band(input logic [7:0] t, lim, input logic [3:0] h);
		logic signed [9:0] ts;
		logic signed [9:0] ls;
		ts = {{2{t[7]}}, t};
		ls = $signed({{2{lim[7]}}, lim}) - $signed({6'h00, h});
		return ts >= ls;
	endfunction : in_hyst_band

	// ----------------------------------------
	// event conditions
	// ----------------------------------------
	masf_pkg::masf_state_t s_reg;
	masf_pkg::masf_state_t s_next;
	masf_pkg::masf_pin14_t pin14_mode;
	logic pin22_timer;
	logic sixth_line_mode;
	logic timer_over;
	logic overtemp_over;
	logic overtemp_hold;
	logic [3:0] fan_slow;
	logic [7:0] cause_first;
	logic [7:0] cause_second;

	assign pin14_mode = masf_pkg::masf_pin14_t'(s_reg.cfg[1:0]);
	assign pin22_timer = s_reg.cfg[`MASF_CFG_PIN22_TIMER];
	assign sixth_line_mode = s_reg.cfg[`MASF_CFG_SIXTH_LINE];
	assign timer_over = overtemp_assert_time > overtemp_timer_limit;

	// overtemp set and hold terms over all three channels
	always_comb begin
		overtemp_over = 1'b0;
		overtemp_hold = 1'b0;
		for (int i = 0; i < 3; i++) begin
			overtemp_over = overtemp_over
				| ($signed(temp_reading[i]) > $signed(overtemp_limit[i]));
			overtemp_hold = overtemp_hold | in_hyst_band(temp_reading[i], overtemp_limit[i],
				overtemp_hysteresis);
		end
	end

	// fan counts grow as the fan slows
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			fan_slow[i] = tach_count[i] > tach_min_count[i];
		end
	end

	// first register causes
	always_comb begin
		cause_first = 8'h00;
		cause_first[0] = pin22_timer ? timer_over : volt_out[0];
		cause_first[3:1] = volt_out[3:1];
		cause_first[6:4] = temp_out;
	end

	// second register causes
	always_comb begin
		cause_second = 8'h00;
		cause_second[0] = sixth_line_mode ? code_moved : volt_out[4];
		cause_second[`MASF_B_OVERTEMP] = overtemp_over;
		cause_second[4:2] = fan_slow[2:0] & fan_drive_on;
		case (pin14_mode)
			masf_pkg::P14_TACH: cause_second[5] = fan_slow[3] & fan_drive_on[2];
			masf_pkg::P14_TIMER: cause_second[5] = timer_over;
			default: cause_second[5] = 1'b0;
		endcase
		cause_second[6] = diode_one_open_short;
		cause_second[7] = diode_two_open_short;
	end

	// ----------------------------------------
	// apb access and next state
	// ----------------------------------------
	logic setup_rd;
	logic acc_rd;
	logic acc_wr;
	logic mapped;
	logic rd_first;
	logic rd_second;
	logic [7:0] clr_second;

	assign setup_rd = psel & ~penable & ~pwrite;
	assign acc_rd = psel & penable & ~pwrite;
	assign acc_wr = psel & penable & pwrite;
	assign mapped = hit(paddr, `MASF_IDX_STATUS_FIRST) | hit(paddr, `MASF_IDX_STATUS_SECOND)
		| hit(paddr, `MASF_IDX_PIN_CONFIG);
	assign rd_first = acc_rd & hit(paddr, `MASF_IDX_STATUS_FIRST);
	assign rd_second = acc_rd & hit(paddr, `MASF_IDX_STATUS_SECOND);

	// overtemp flag may only be cleared once below the hysteresis band
	always_comb begin
		clr_second = {8{rd_second}};
		clr_second[`MASF_B_OVERTEMP] = rd_second & ~overtemp_hold;
	end

	// one next-state copy of the whole register state
	always_comb begin
		s_next = s_reg;
		// clear takes effect at the access edge, after setup captured the data
		s_next.first = 7'(sticky({1'b0, s_reg.first}, cause_first, {8{rd_first}}));
		s_next.second = sticky(s_reg.second, cause_second, clr_second);
		// spare pin modes replace the flag with a level
		case (pin14_mode)
			masf_pkg::P14_GPIO_OUT: s_next.second[`MASF_B_SHARED] = s_reg.spare;
			masf_pkg::P14_GPIO_IN: s_next.second[`MASF_B_SHARED] = spare_io_six_i;
			default: s_next.second[`MASF_B_SHARED] = s_next.second[`MASF_B_SHARED];
		endcase
		// only the spare bit of the status pair accepts writes
		if (acc_wr && pstrb[0] && hit(paddr, `MASF_IDX_STATUS_SECOND)
			&& pin14_mode == masf_pkg::P14_GPIO_OUT) begin
			s_next.spare = pwdata[`MASF_B_SHARED];
		end
		if (acc_wr && pstrb[0] && hit(paddr, `MASF_IDX_PIN_CONFIG)) begin
			s_next.cfg = pwdata[3:0];
		end
		// read data captured in setup so it shows the pre-read flags
		if (setup_rd) begin
			if (hit(paddr, `MASF_IDX_STATUS_FIRST)) begin
				s_next.rdata = {24'h000000, |s_reg.second, s_reg.first};
			end else if (hit(paddr, `MASF_IDX_STATUS_SECOND)) begin
				s_next.rdata = {24'h000000, s_reg.second};
			end else if (hit(paddr, `MASF_IDX_PIN_CONFIG)) begin
				s_next.rdata = {28'h0000000, s_reg.cfg};
			end else begin
				s_next.rdata = 32'h00000000;
			end
		end
	end

	// all state in one register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg.first <= 7'h00;
			s_reg.second <= `MASF_STATUS_RESET;
			s_reg.cfg <= `MASF_CFG_RESET;
			s_reg.spare <= 1'b0;
			s_reg.rdata <= 32'h00000000;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata = s_reg.rdata;
	assign pready = 1'b1; // zero wait states
	assign pslverr = psel & penable & ~mapped;
	assign spare_io_six_o = s_reg.spare;
	assign spare_io_six_oe = (pin14_mode == masf_pkg::P14_GPIO_OUT);
	assign voltage_code_change_flag = sixth_line_mode & s_reg.second[0];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_volt_set;
		@(posedge pclk) disable iff (!presetn)
		(volt_out[1] && volt_reading[1] > volt_high_limit[1]) |=> s_reg.first[1];
	endproperty
	a_volt_set: assert property (p_volt_set) else $error("core flag missed");

	property p_hold_on_read;
		@(posedge pclk) disable iff (!presetn)
		(rd_first && cause_first[2]) |=> s_reg.first[2] ##1 s_reg.first[2] || !rd_first;
	endproperty
	a_hold_on_read: assert property (p_hold_on_read) else $error("live flag cleared");

	property p_clear_on_read;
		@(posedge pclk) disable iff (!presetn)
		(rd_first && !cause_first[3]) |=> !s_reg.first[3];
	endproperty
	a_clear_on_read: assert property (p_clear_on_read) else $error("flag not cleared");

	property p_summary;
		@(posedge pclk) disable iff (!presetn)
		(setup_rd && hit(paddr, `MASF_IDX_STATUS_FIRST))
			|=> prdata[`MASF_B_SUMMARY] == ($past(s_reg.second) != 8'h00);
	endproperty
	a_summary: assert property (p_summary) else $error("summary bit wrong");

	property p_overtemp_band;
		@(posedge pclk) disable iff (!presetn)
		(s_reg.second[`MASF_B_OVERTEMP] && overtemp_hold) |=> s_reg.second[`MASF_B_OVERTEMP];
	endproperty
	a_overtemp_band: assert property (p_overtemp_band) else $error("overtemp cleared early");

	property p_timer_flag;
		@(posedge pclk) disable iff (!presetn)
		(pin14_mode == masf_pkg::P14_TIMER && timer_over) |=> s_reg.second[`MASF_B_SHARED];
	endproperty
	a_timer_flag: assert property (p_timer_flag) else $error("timer flag missed");

	property p_pin22_timer;
		@(posedge pclk) disable iff (!presetn)
		(pin22_timer && timer_over) |=> s_reg.first[0];
	endproperty
	a_pin22_timer: assert property (p_pin22_timer) else $error("first timer flag missed");

	property p_fan_gate;
		@(posedge pclk) disable iff (!presetn)
		(!fan_drive_on[0] && !s_reg.second[2]) |=> !s_reg.second[2];
	endproperty
	a_fan_gate: assert property (p_fan_gate) else $error("fan flag with drive off");

	property p_fan4_gate;
		@(posedge pclk) disable iff (!presetn)
		(pin14_mode == masf_pkg::P14_TACH && !fan_drive_on[2] && !s_reg.second[5]
			&& !acc_wr) |=> !s_reg.second[5];
	endproperty
	a_fan4_gate: assert property (p_fan4_gate) else $error("fan four flag with drive off");

	property p_spare_write;
		@(posedge pclk) disable iff (!presetn)
		(acc_wr && pstrb[0] && hit(paddr, `MASF_IDX_STATUS_SECOND)
			&& pin14_mode == masf_pkg::P14_GPIO_OUT)
			|=> spare_io_six_o == $past(pwdata[5]) ##1 s_reg.second[5] == spare_io_six_o
			|| pin14_mode != masf_pkg::P14_GPIO_OUT;
	endproperty
	a_spare_write: assert property (p_spare_write) else $error("spare level wrong");

	property p_read_before_clear;
		@(posedge pclk) disable iff (!presetn)
		(setup_rd && hit(paddr, `MASF_IDX_STATUS_SECOND)) |=> prdata[7:0] == $past(s_reg.second);
	endproperty
	a_read_before_clear: assert property (p_read_before_clear) else $error("read data late");

endmodule : masf_top

`default_nettype wire

// ===== testbench/masf_host.sv
`default_nettype none

// apb master standing in for the host that polls the alarm flags
module masf_host (
	// clock
	input wire logic pclk,
	// request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	// answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
	end

	// one transfer; everything held until pready is seen high at an edge
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : masf_host

`default_nettype wire

// ===== testbench/masf_top_bench.sv
`include "masf_consts.svh"
`default_nettype none

module masf_top_bench;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [7:0] I1 = `MASF_IDX_STATUS_FIRST;
	localparam logic [7:0] I2 = `MASF_IDX_STATUS_SECOND;
	localparam logic [7:0] IC = `MASF_IDX_PIN_CONFIG;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] pstrb, overtemp_hysteresis;
	logic [4:0][7:0] volt_reading, volt_low_limit, volt_high_limit;
	logic [2:0][7:0] temp_reading, temp_low_limit, temp_high_limit, overtemp_limit;
	logic [7:0] overtemp_assert_time, overtemp_timer_limit;
	logic [3:0][15:0] tach_count, tach_min_count;
	logic [2:0] fan_drive_on;
	logic diode_one_open_short, diode_two_open_short, e;
	logic [5:0] processor_voltage_code;
	logic spare_io_six_i, spare_io_six_o, spare_io_six_oe, voltage_code_change_flag;
	int n_errors = 0;
	int n_checks = 0;
	int cycles = 0;

	masf_top #(.TACH_W(16), .CODE_CYCLES(8)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.volt_reading(volt_reading), .volt_low_limit(volt_low_limit),
		.volt_high_limit(volt_high_limit), .temp_reading(temp_reading),
		.temp_low_limit(temp_low_limit), .temp_high_limit(temp_high_limit),
		.overtemp_limit(overtemp_limit), .overtemp_hysteresis(overtemp_hysteresis),
		.overtemp_assert_time(overtemp_assert_time),
		.overtemp_timer_limit(overtemp_timer_limit),
		.tach_count(tach_count), .tach_min_count(tach_min_count),
		.fan_drive_on(fan_drive_on), .diode_one_open_short(diode_one_open_short),
		.diode_two_open_short(diode_two_open_short),
		.processor_voltage_code(processor_voltage_code), .spare_io_six_i(spare_io_six_i),
		.spare_io_six_o(spare_io_six_o), .spare_io_six_oe(spare_io_six_oe),
		.voltage_code_change_flag(voltage_code_change_flag));

	masf_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		u_host.xfer(1'b0, idx, 32'h0, q, e);
		check(q, exp, "status read");
	endtask : rd

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		u_host.xfer(1'b1, idx, d, q, e);
	endtask : wr

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	// ----------------------------------------
	// clock, hang guard
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// the whole run is well under a thousand cycles
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			results();
		end
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		volt_reading <= {5{8'h80}};
		volt_low_limit <= {5{8'h10}};
		volt_high_limit <= {5{8'hF0}};
		temp_reading <= {3{8'h20}};
		temp_low_limit <= {3{8'h81}};
		temp_high_limit <= {3{8'h7F}};
		overtemp_limit <= {3{8'h50}};
		overtemp_hysteresis <= 4'h4;
		overtemp_assert_time <= 8'h00;
		overtemp_timer_limit <= 8'h40;
		tach_count <= {4{16'h0080}};
		tach_min_count <= {4{16'h0100}};
		fan_drive_on <= 3'b111;
		diode_one_open_short <= 1'b0;
		diode_two_open_short <= 1'b0;
		processor_voltage_code <= 6'h00;
		spare_io_six_i <= 1'b0;
		tick(3);
		presetn <= 1'b1;
		rd(I1, 32'h0);
		rd(I2, 32'h0);
		u_host.xfer(1'b0, 8'h10, 32'h0, q, e);
		check({31'h0, e}, 32'h1, "unmapped error");
		wr(I1, 32'hFF);
		rd(I1, 32'h0);
		$display("test reset done");
		// voltages: high boundary, low boundary, latch, clear
		for (int i = 0; i < 4; i++) begin
			volt_reading[i] <= 8'hF0;
			tick(2);
			rd(I1, 32'h0);
			volt_reading[i] <= 8'hF1;
			tick(2);
			rd(I1, 32'h1 << i);
			volt_reading[i] <= 8'h10;
			tick(2);
			rd(I1, 32'h1 << i);
			volt_reading[i] <= 8'h80;
			tick(2);
			rd(I1, 32'h1 << i);
			rd(I1, 32'h0);
		end
		// temperatures are signed: 0x90 is inside, 0x81 sits on the low limit
		for (int i = 0; i < 3; i++) begin
			temp_reading[i] <= 8'h90;
			tick(2);
			rd(I1, 32'h0);
			temp_reading[i] <= 8'h81;
			tick(2);
			rd(I1, 32'h10 << i);
			temp_reading[i] <= 8'h20;
			tick(2);
			rd(I1, 32'h10 << i);
			rd(I1, 32'h0);
		end
		volt_reading[4] <= 8'hFF;
		tick(2);
		rd(I1, 32'h80);
		rd(I2, 32'h1);
		volt_reading[4] <= 8'h80;
		tick(2);
		rd(I2, 32'h1);
		rd(I1, 32'h0);
		$display("test limits done");
		// fans: suppressed while drive off, one above minimum count alarms
		for (int i = 0; i < 4; i++) begin
			fan_drive_on[(i < 3) ? i : 2] <= 1'b0;
			tach_count[i] <= 16'h0101;
			tick(2);
			rd(I2, 32'h0);
			fan_drive_on[(i < 3) ? i : 2] <= 1'b1;
			tick(2);
			rd(I2, 32'h4 << i);
			tach_count[i] <= 16'h0100;
			tick(2);
			rd(I2, 32'h4 << i);
			rd(I2, 32'h0);
		end
		for (int i = 0; i < 2; i++) begin
			{diode_two_open_short, diode_one_open_short} <= 2'b01 << i;
			tick(2);
			rd(I2, 32'h40 << i);
			{diode_two_open_short, diode_one_open_short} <= 2'b00;
			tick(2);
			rd(I2, 32'h40 << i);
			rd(I2, 32'h0);
		end
		$display("test fans and diodes done");
		// overtemp holds until below limit minus hysteresis
		temp_reading[1] <= 8'h60;
		tick(2);
		rd(I2, 32'h2);
		temp_reading[1] <= 8'h4C;
		tick(2);
		rd(I2, 32'h2);
		temp_reading[1] <= 8'h4B;
		tick(2);
		rd(I2, 32'h2);
		rd(I2, 32'h0);
		$display("test overtemp done");
		// spare pin as output, then as input
		wr(IC, 32'h1);
		wr(I2, 32'h20);
		tick(1);
		check({30'h0, spare_io_six_oe, spare_io_six_o}, 32'h3, "spare out");
		wr(I2, 32'h0);
		tick(1);
		check({31'h0, spare_io_six_o}, 32'h0, "spare low");
		wr(IC, 32'h2);
		spare_io_six_i <= 1'b1;
		tick(2);
		rd(I2, 32'h20);
		check({31'h0, spare_io_six_oe}, 32'h0, "spare input");
		spare_io_six_i <= 1'b0;
		tick(2);
		rd(I2, 32'h0);
		$display("test spare pin done");
		// timer alarms on both shared positions
		wr(IC, 32'h7);
		overtemp_assert_time <= 8'h40;
		tick(2);
		rd(I1, 32'h0);
		overtemp_assert_time <= 8'h41;
		tick(2);
		rd(I1, 32'h81);
		overtemp_assert_time <= 8'h00;
		tick(2);
		rd(I2, 32'h20);
		rd(I1, 32'h01);
		rd(I1, 32'h0);
		$display("test timer done");
		// processor voltage code change
		wr(IC, 32'h8);
		tick(20);
		processor_voltage_code <= 6'h15;
		tick(30);
		check({31'h0, voltage_code_change_flag}, 32'h1, "code change out");
		rd(I2, 32'h1);
		rd(I2, 32'h0);
		check({31'h0, voltage_code_change_flag}, 32'h0, "code change low");
		$display("test voltage code done");
		// mid-run reset wipes a latched flag whose cause has already gone
		diode_one_open_short <= 1'b1;
		tick(2);
		diode_one_open_short <= 1'b0;
		presetn <= 1'b0;
		tick(2);
		presetn <= 1'b1;
		rd(I2, 32'h0);
		check({30'h0, spare_io_six_oe, voltage_code_change_flag}, 32'h0, "outputs reset");
		$display("test reset again done");
		results();
	end
endmodule : masf_top_bench

`default_nettype wire
